// ===== design/hdx_pkg.sv
package hdx_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LIST0 = 8'h04;
  localparam logic [7:0] A_LIST1 = 8'h08;
  localparam logic [7:0] A_EOT = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_PRST = 8'h14;
  localparam logic [7:0] A_PRES = 8'h18;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // descriptor: six 16-bit words, little endian
  localparam int TD_WORDS = 6;
  localparam logic [2:0] W_BUF = 3'h0;
  localparam logic [2:0] W_PLEN = 3'h1;
  localparam logic [2:0] W_TOK = 3'h2;
  localparam logic [2:0] W_CTL = 3'h3;
  localparam logic [2:0] W_RTY = 3'h4;
  localparam logic [2:0] W_LINK = 3'h5;
  // status byte bits
  localparam int S_ACK = 0;
  localparam int S_ERR = 1;
  localparam int S_TOUT = 2;
  localparam int S_SEQ = 3;
  localparam int S_OVF = 5;
  localparam int S_NAK = 6;
  localparam int S_STALL = 7;
  // retry byte fields
  localparam int R_CNT = 0;
  localparam int R_KIND = 2;
  localparam int R_ACT = 4;
  localparam logic [1:0] K_CTL = 2'h0;
  localparam logic [1:0] K_ISO = 2'h1;
  localparam logic [1:0] K_BULK = 2'h2;
  localparam logic [1:0] K_INT = 2'h3;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam int C_PRE = 7;
  localparam int C_TOG = 6;
  localparam logic [15:0] MBOX0 = 16'h0144;
  localparam logic [15:0] MBOX1 = 16'h0148;
  localparam logic [15:0] MSG_DONE = 16'h1000;
  // bus time, tenths of a full-speed bit
  localparam int CLK_NS = 100;
  localparam int BIT_TENTHS_PER_US = 120;
  localparam int TENTHS_PER_CLK = CLK_NS * BIT_TENTHS_PER_US / 1000;
  localparam int FRAME_BITS = 12000;
  localparam int HOST_DLY = 1060;
  localparam int XFER_SETUP = 210;
  localparam int FS_BASE = 1125;
  localparam int FS_ISO_IN = 905;
  localparam int FS_ISO_OUT = 784;
  localparam int FS_PER = 94;
  localparam int LS_IN_BASE = 8024;
  localparam int LS_IN_PER = 758;
  localparam int LS_OUT_BASE = 8026;
  localparam int LS_OUT_PER = 747;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [1:0]  be;
  } mem_req_t;

  typedef struct packed {
    logic        req;
    logic [3:0]  pid;
    logic [3:0]  ep;
    logic [6:0]  dev;
    logic [1:0]  port;
    logic [9:0]  len;
    logic [15:0] buf_ptr;
    logic        toggle;
    logic        pre;
    logic        iso;
  } txn_req_t;

  typedef struct packed {
    logic       ack;
    logic       err;
    logic       tout;
    logic       nak;
    logic       stall;
    logic       seq;
    logic [9:0] cnt;
  } txn_res_t;
endpackage

// ===== design/hdx_exec.sv
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module hdx_exec
  import hdx_pkg::*;
#(
  parameter int MS_CYCLES = CYC_PER_MS
) (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  // axi4-lite slave
  input  wire logic [7:0]        i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [7:0]        i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // shared memory
  output hdx_pkg::mem_req_t      o_mem,
  input  wire logic              i_mem_ack,
  input  wire logic [15:0]       i_mem_rdata,
  // usb transaction engine
  input  wire logic              i_sof,
  output hdx_pkg::txn_req_t      o_txn,
  input  wire logic              i_txn_done,
  input  wire hdx_pkg::txn_res_t i_txn_res,
  // downstream ports
  output logic [3:0]             o_port_reset,
  input  wire logic [3:0]        i_port_attached,
  input  wire logic [3:0]        i_port_low_speed
);
  import hdx_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CHECK, ST_FETCH, ST_EVAL, ST_ISSUE,
    ST_WB_ST, ST_WB_RT, ST_LINK, ST_MBOX
  } st_t;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [31:0] ctrl_r;
  logic [15:0] list_r [2];
  logic [15:0] eot_r;
  logic [1:0]  prst_port_r;
  logic [15:0] prst_ms_r;
  logic        prst_go_r;
  logic [1:0]  pres_r;
  logic        prst_busy_r;
  logic [1:0]  list_clr_r;
  logic        eng_r;
  st_t         st_r;
  logic        wr_go;
  logic [31:0] wmask;

  assign wr_go = i_awvalid & i_wvalid & ~o_bvalid & ~o_awready;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{i_wstrb[b]}};
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
    end else begin
      o_awready <= wr_go;
      o_wready  <= wr_go;
      if (wr_go) begin
        o_bvalid <= 1'b1;
        if (i_awaddr == A_CTRL || i_awaddr == A_LIST0 || i_awaddr == A_LIST1
            || i_awaddr == A_EOT || i_awaddr == A_PRST) begin
          o_bresp <= 2'h0;
        end else begin
          o_bresp <= 2'h2;
        end
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r      <= CTRL_RST;
      list_r[0]   <= 16'h0000;
      list_r[1]   <= 16'h0000;
      eot_r       <= 16'h0000;
      prst_port_r <= 2'h0;
      prst_ms_r   <= 16'h0000;
      prst_go_r   <= 1'b0;
    end else begin
      prst_go_r <= 1'b0;
      // finished list leaves its pointer cell empty
      if (list_clr_r[0]) begin
        list_r[0] <= 16'h0000;
      end
      if (list_clr_r[1]) begin
        list_r[1] <= 16'h0000;
      end
      if (wr_go) begin
        if (i_awaddr == A_CTRL) begin
          ctrl_r <= (ctrl_r & ~wmask) | (i_wdata & wmask);
        end else if (i_awaddr == A_LIST0) begin
          list_r[0] <= (list_r[0] & ~wmask[15:0]) | (i_wdata[15:0] & wmask[15:0]);
        end else if (i_awaddr == A_LIST1) begin
          list_r[1] <= (list_r[1] & ~wmask[15:0]) | (i_wdata[15:0] & wmask[15:0]);
        end else if (i_awaddr == A_EOT) begin
          eot_r <= (eot_r & ~wmask[15:0]) | (i_wdata[15:0] & wmask[15:0]);
        end else if (i_awaddr == A_PRST && !prst_busy_r) begin
          prst_port_r <= i_wdata[1:0];
          prst_ms_r   <= i_wdata[31:16];
          prst_go_r   <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= 2'h0;
    end else begin
      o_arready <= i_arvalid & ~o_rvalid & ~o_arready;
      if (i_arvalid && !o_rvalid && !o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp  <= 2'h0;
        if (i_araddr == A_CTRL) begin
          o_rdata <= ctrl_r;
        end else if (i_araddr == A_LIST0) begin
          o_rdata <= {16'h0000, list_r[0]};
        end else if (i_araddr == A_LIST1) begin
          o_rdata <= {16'h0000, list_r[1]};
        end else if (i_araddr == A_EOT) begin
          o_rdata <= {16'h0000, eot_r};
        end else if (i_araddr == A_STAT) begin
          o_rdata <= {27'h0, eng_r, st_r};
        end else if (i_araddr == A_PRST) begin
          o_rdata <= {prst_ms_r, 13'h0, prst_busy_r, prst_port_r};
        end else if (i_araddr == A_PRES) begin
          o_rdata <= {30'h0, pres_r};
        end else begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= 2'h2;
        end
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port reset service
  logic [31:0] prst_cnt_r;
  logic [15:0] prst_left_r;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      prst_busy_r  <= 1'b0;
      prst_cnt_r   <= 32'h0;
      prst_left_r  <= 16'h0;
      o_port_reset <= 4'h0;
      pres_r       <= 2'h0;
    end else if (prst_go_r) begin
      prst_busy_r  <= 1'b1;
      prst_cnt_r   <= 32'h0;
      prst_left_r  <= prst_ms_r;
      o_port_reset <= 4'h1 << prst_port_r;
    end else if (prst_busy_r) begin
      if (prst_cnt_r == 32'(MS_CYCLES - 1) || prst_left_r == 16'h0) begin
        prst_cnt_r <= 32'h0;
        if (prst_left_r <= 16'h1) begin
          prst_busy_r  <= 1'b0;
          o_port_reset <= 4'h0;
          pres_r <= {~i_port_attached[prst_port_r],
                     i_port_low_speed[prst_port_r]};
        end else begin
          prst_left_r <= prst_left_r - 16'h1;
        end
      end else begin
        prst_cnt_r <= prst_cnt_r + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame time and budget
  logic [23:0] el_r;
  logic [23:0] limit;
  logic [23:0] cost;
  logic [15:0] w_r [TD_WORDS];
  logic [9:0]  len;
  logic [1:0]  kind;
  logic        is_in;

  assign len   = w_r[W_PLEN][9:0];
  assign kind  = w_r[W_RTY][R_KIND +: 2];
  assign is_in = w_r[W_TOK][7:4] == PID_IN;
  // zero end-of-transfer point means the whole frame
  assign limit = (eot_r == 16'h0) ? 24'(FRAME_BITS * 10) : 24'(eot_r) * 24'd10;

  always_comb begin
    cost = 24'(HOST_DLY + XFER_SETUP);
    if (w_r[W_CTL][C_PRE]) begin
      if (is_in) begin
        cost = cost + 24'(LS_IN_BASE) + 24'(len) * 24'(LS_IN_PER);
      end else begin
        cost = cost + 24'(LS_OUT_BASE) + 24'(len) * 24'(LS_OUT_PER);
      end
    end else begin
      cost = cost + 24'(len) * 24'(FS_PER);
      if (kind != K_ISO) begin
        cost = cost + 24'(FS_BASE);
      end else if (is_in) begin
        cost = cost + 24'(FS_ISO_IN);
      end else begin
        cost = cost + 24'(FS_ISO_OUT);
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      el_r <= 24'h0;
    end else if (i_sof) begin
      el_r <= 24'h0;
    end else if (el_r < limit) begin
      el_r <= el_r + 24'(TENTHS_PER_CLK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // descriptor walker
  logic [15:0] td_r;
  logic [2:0]  widx_r;
  logic [7:0]  stat_r;
  logic [7:0]  res_r;
  logic [1:0]  rcnt_r;
  logic        act_r;
  logic        halt_v_r;
  logic [12:0] halt_pipe_r;
  logic [12:0] pipe;
  logic        mreq_r;
  logic        serious;
  logic [9:0]  rcv;

  assign pipe = {w_r[W_PLEN][15:14], w_r[W_TOK][3:0], w_r[W_TOK][14:8]};
  assign rcv  = i_txn_res.cnt;
  assign serious = i_txn_res.stall
                   | (is_in & i_txn_res.ack & (i_txn_res.seq != w_r[W_CTL][C_TOG]))
                   | (is_in & i_txn_res.ack & kind != K_ISO & rcv != len);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_r        <= ST_IDLE;
      eng_r       <= 1'b0;
      td_r        <= 16'h0;
      widx_r      <= 3'h0;
      stat_r      <= 8'h0;
      res_r       <= 8'h0;
      rcnt_r      <= 2'h0;
      act_r       <= 1'b0;
      halt_v_r    <= 1'b0;
      halt_pipe_r <= 13'h0;
      mreq_r      <= 1'b0;
      list_clr_r  <= 2'h0;
      o_mem       <= '0;
      o_txn       <= '0;
      for (int i = 0; i < TD_WORDS; i++) begin
        w_r[i] <= 16'h0;
      end
    end else begin
      list_clr_r <= 2'h0;
      o_mem.req  <= mreq_r & ~i_mem_ack;
      mreq_r     <= mreq_r & ~i_mem_ack;
      case (st_r)
        ST_IDLE: begin
          if (i_sof && ctrl_r[0]) begin
            eng_r    <= 1'b0;
            halt_v_r <= 1'b0;
            st_r     <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (list_r[eng_r] != 16'h0) begin
            td_r   <= list_r[eng_r];
            widx_r <= 3'h0;
            st_r   <= ST_FETCH;
          end else if (!eng_r) begin
            eng_r <= 1'b1;
          end else begin
            st_r <= ST_IDLE;
          end
        end
        ST_FETCH: begin
          if (!mreq_r) begin
            mreq_r <= 1'b1;
            o_mem  <= '{1'b1, 1'b0, td_r + 16'({widx_r, 1'b0}), 16'h0, 2'h3};
          end else if (i_mem_ack) begin
            w_r[widx_r] <= i_mem_rdata;
            if (widx_r == 3'(TD_WORDS - 1)) begin
              st_r <= ST_EVAL;
            end else begin
              widx_r <= widx_r + 3'h1;
            end
          end
        end
        ST_EVAL: begin
          stat_r <= w_r[W_CTL][15:8];
          res_r  <= w_r[W_RTY][15:8];
          rcnt_r <= w_r[W_RTY][R_CNT +: 2];
          act_r  <= w_r[W_RTY][R_ACT];
          if (!w_r[W_RTY][R_ACT]) begin
            st_r <= ST_LINK;
          end else if (halt_v_r && halt_pipe_r == pipe) begin
            stat_r <= 8'h0;
            act_r  <= 1'b0;
            st_r   <= ST_WB_ST;
          end else if (el_r + cost > limit) begin
            st_r <= ST_ISSUE;
          end else begin
            o_txn <= '{1'b1, w_r[W_TOK][7:4], w_r[W_TOK][3:0], w_r[W_TOK][14:8],
                       w_r[W_PLEN][15:14], len, w_r[W_BUF],
                       w_r[W_CTL][C_TOG], w_r[W_CTL][C_PRE], kind == K_ISO};
            st_r  <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (!o_txn.req) begin
            // frame budget spent: leave descriptor active for the next frame
            st_r <= ST_IDLE;
          end else if (i_txn_done) begin
            o_txn.req <= 1'b0;
            stat_r    <= 8'h0;
            stat_r[S_SEQ]   <= i_txn_res.seq;
            stat_r[S_ACK]   <= i_txn_res.ack;
            stat_r[S_ERR]   <= i_txn_res.err;
            stat_r[S_TOUT]  <= i_txn_res.tout;
            stat_r[S_NAK]   <= i_txn_res.nak;
            stat_r[S_STALL] <= i_txn_res.stall;
            stat_r[S_OVF]   <= is_in & i_txn_res.ack & kind != K_ISO & rcv != len;
            res_r <= (is_in && rcv != len) ? 8'(len - rcv) : 8'h0;
            st_r  <= ST_WB_ST;
            act_r <= 1'b0;
            if (serious) begin
              halt_v_r    <= 1'b1;
              halt_pipe_r <= pipe;
            end else if (kind == K_ISO || kind == K_INT) begin
              act_r <= 1'b0;
            end else if (i_txn_res.nak) begin
              act_r <= 1'b1;
              st_r  <= ST_EVAL;
            end else if ((i_txn_res.err || i_txn_res.tout) && rcnt_r != 2'h0) begin
              rcnt_r <= rcnt_r - 2'h1;
              w_r[W_RTY][R_CNT +: 2] <= rcnt_r - 2'h1;
              act_r  <= 1'b1;
              st_r   <= ST_EVAL;
            end
          end
        end
        ST_WB_ST: begin
          if (!mreq_r) begin
            mreq_r <= 1'b1;
            o_mem  <= '{1'b1, 1'b1, td_r + 16'({W_CTL, 1'b0}), {stat_r, 8'h0}, 2'h2};
          end else if (i_mem_ack) begin
            st_r <= ST_WB_RT;
          end
        end
        ST_WB_RT: begin
          if (!mreq_r) begin
            mreq_r <= 1'b1;
            o_mem  <= '{1'b1, 1'b1, td_r + 16'({W_RTY, 1'b0}),
                        {res_r, 3'h0, act_r, kind, rcnt_r}, 2'h3};
          end else if (i_mem_ack) begin
            st_r <= ST_LINK;
          end
        end
        ST_LINK: begin
          if (w_r[W_LINK] == 16'h0) begin
            st_r <= ST_MBOX;
          end else begin
            td_r   <= w_r[W_LINK];
            widx_r <= 3'h0;
            st_r   <= ST_FETCH;
          end
        end
        ST_MBOX: begin
          if (!mreq_r) begin
            mreq_r <= 1'b1;
            o_mem  <= '{1'b1, 1'b1, eng_r ? MBOX1 : MBOX0, MSG_DONE, 2'h3};
          end else if (i_mem_ack) begin
            list_clr_r[eng_r] <= 1'b1;
            st_r       <= ST_CHECK;
            if (eng_r) begin
              st_r <= ST_IDLE;
            end else begin
              eng_r <= 1'b1;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== tb/hdx_exec_sva.sv
`timescale 1ns/1ns
`default_nettype none
module hdx_exec_chk
  import hdx_pkg::*;
#(
  parameter int MS_CYCLES = 10
) (
  // clock and reset
  input wire logic              i_mclk,
  input wire logic              i_rst,
  // register bus
  input wire logic              i_awvalid,
  input wire logic              i_wvalid,
  input wire logic              i_bready,
  input wire logic              i_arvalid,
  input wire logic              i_rready,
  input wire logic              o_awready,
  input wire logic              o_wready,
  input wire logic              o_bvalid,
  input wire logic [1:0]        o_bresp,
  input wire logic              o_arready,
  input wire logic              o_rvalid,
  input wire logic [31:0]       o_rdata,
  // memory, transactions, ports
  input wire hdx_pkg::mem_req_t o_mem,
  input wire logic              i_mem_ack,
  input wire hdx_pkg::txn_req_t o_txn,
  input wire logic              i_txn_done,
  input wire logic [3:0]        o_port_reset
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_write_answer: assert property (
    i_awvalid && i_wvalid && !o_bvalid && !o_awready |=> o_awready && o_wready && o_bvalid)
    else $error("write not answered in one cycle");
  a_read_answer: assert property (
    i_arvalid && !o_rvalid && !o_arready |=> o_arready && o_rvalid)
    else $error("read not answered in one cycle");
  a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  a_mem_hold: assert property (o_mem.req && !i_mem_ack |=> o_mem.req && $stable(o_mem))
    else $error("memory request changed before ack");
  a_mem_gap: assert property (o_mem.req && i_mem_ack |=> !o_mem.req)
    else $error("memory request not released after ack");
  a_txn_hold: assert property (o_txn.req && !i_txn_done |=> o_txn.req && $stable(o_txn))
    else $error("transaction request changed before done");
  a_txn_gap: assert property (i_txn_done |=> !o_txn.req)
    else $error("transaction reissued at once");
  a_done_msg: assert property (
    o_mem.req && o_mem.we && (o_mem.addr == MBOX0 || o_mem.addr == MBOX1)
    |-> o_mem.wdata == MSG_DONE && o_mem.be == 2'h3)
    else $error("bad list done message");
  a_port_onehot: assert property ($onehot0(o_port_reset))
    else $error("more than one port in reset");
endmodule

bind hdx_exec hdx_exec_chk #(.MS_CYCLES(MS_CYCLES)) i_hdx_exec_chk (.*);
`default_nettype wire

// ===== tb/far_model.sv
`timescale 1ns/1ns
`default_nettype none
module far_model
  import hdx_pkg::*;
(
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  // shared memory
  input  wire hdx_pkg::mem_req_t i_mem,
  output logic                   o_ack,
  output logic [15:0]            o_rdata,
  // transaction engine
  input  wire hdx_pkg::txn_req_t i_txn,
  input  wire hdx_pkg::txn_res_t i_res,
  output logic                   o_done,
  output hdx_pkg::txn_res_t      o_res
);
  logic [15:0] mem [0:511];
  logic [1:0]  mcnt_r;
  logic [1:0]  tcnt_r;

  // words at addr bit1 set answer two cycles late; idle data toggles
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      mcnt_r <= 2'h0;
      o_rdata <= 16'h0;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_mem.req && !o_ack) begin
        mcnt_r <= mcnt_r + 2'h1;
        if (mcnt_r == {i_mem.addr[1], 1'b0}) begin
          o_ack <= 1'b1;
          mcnt_r <= 2'h0;
          o_rdata <= mem[i_mem.addr[9:1]];
          if (i_mem.we && i_mem.be[0]) mem[i_mem.addr[9:1]][7:0] <= i_mem.wdata[7:0];
          if (i_mem.we && i_mem.be[1]) mem[i_mem.addr[9:1]][15:8] <= i_mem.wdata[15:8];
        end
      end
    end
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_done <= 1'b0;
      tcnt_r <= 2'h0;
      o_res <= '0;
    end else begin
      o_done <= 1'b0;
      o_res <= ~o_res;
      if (i_txn.req && !o_done) begin
        tcnt_r <= tcnt_r + 2'h1;
        if (tcnt_r == 2'h3) begin
          o_done <= 1'b1;
          o_res <= i_res;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/usb_host_descriptor_executor_tb.sv
`timescale 1ns/1ns
`default_nettype none
module usb_host_descriptor_executor_tb;
  import hdx_pkg::*;
  typedef struct packed {
    logic [1:0] kind;
    logic [3:0] pid;
    txn_res_t   res;
    logic       halt;
    logic [7:0] st;
    logic [7:0] rty;
    logic [7:0] rsd;
  } row_t;
  logic        i_mclk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_sof;
  logic        i_mem_ack, i_txn_done, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [3:0]  i_wstrb, o_port_reset, i_port_attached, i_port_low_speed;
  logic [1:0]  o_bresp, o_rresp, rr;
  logic [15:0] i_mem_rdata;
  mem_req_t    o_mem;
  txn_req_t    o_txn;
  txn_res_t    i_txn_res, res_sel;
  int          errors, n_checks;
  row_t        rows [10];

  hdx_exec #(.MS_CYCLES(10)) i_hdx_exec (.*);
  far_model i_far_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_mem(o_mem), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata), .i_txn(o_txn), .i_res(res_sel), .o_done(i_txn_done),
    .o_res(i_txn_res));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  initial begin
    #8000000;
    errors++;
    wrap_up();
  end
  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit b;
    @(posedge i_mclk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!b) begin
      @(posedge i_mclk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) begin
        b = 1;
        i_bready <= 1'b0;
        rr = o_bresp;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    bit r;
    @(posedge i_mclk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    while (!r) begin
      @(posedge i_mclk);
      if (o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) begin
        r = 1;
        i_rready <= 1'b0;
        rd = o_rdata;
        rr = o_rresp;
      end
    end
  endtask

  function automatic logic [15:0] w(input int a);
    return i_far_model.mem[a];
  endfunction

  // port 0, length 8, device 3, endpoint 2
  task automatic put_td(input int a, input row_t r, input logic [15:0] link);
    i_far_model.mem[a] = 16'h0400;
    i_far_model.mem[a+1] = 16'h0008;
    i_far_model.mem[a+2] = {8'h03, r.pid, 4'h2};
    i_far_model.mem[a+3] = {8'h00, 3'h0, r.kind == K_ISO, 4'h1};
    i_far_model.mem[a+4] = {8'h00, 3'h0, 1'b1, r.kind, 2'h3};
    i_far_model.mem[a+5] = link;
  endtask

  // one frame start, then wait for the list done message
  task automatic run_list;
    @(posedge i_mclk);
    i_sof <= 1'b1;
    @(posedge i_mclk);
    i_sof <= 1'b0;
    for (int k = 0; k < 5000 && w(16'ha2) !== MSG_DONE; k++) @(posedge i_mclk);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{K_BULK, 4'h1, 16'h8000, 1'b0, 8'h01, 8'h0b, 8'h00},
             '{K_CTL, PID_IN, 16'h8008, 1'b0, 8'h01, 8'h03, 8'h00},
             '{K_BULK, PID_IN, 16'h8005, 1'b1, 8'h21, 8'h0b, 8'h03},
             '{K_BULK, PID_IN, 16'h800a, 1'b1, 8'h21, 8'h0b, 8'hfe},
             '{K_BULK, 4'h1, 16'h0800, 1'b1, 8'h80, 8'h0b, 8'h00},
             '{K_BULK, 4'h1, 16'h2000, 1'b0, 8'h04, 8'h08, 8'h00},
             '{K_CTL, 4'h1, 16'h4000, 1'b0, 8'h02, 8'h00, 8'h00},
             '{K_ISO, PID_IN, 16'h4000, 1'b0, 8'h02, 8'h07, 8'h08},
             '{K_INT, PID_IN, 16'h2000, 1'b0, 8'h04, 8'h0f, 8'h08},
             '{K_BULK, PID_IN, 16'h8408, 1'b1, 8'h09, 8'h0b, 8'h00}};
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_sof} = '0;
    {i_awaddr, i_araddr, i_wdata, i_port_attached, i_port_low_speed} = '0;
    i_wstrb = 4'hf;
    res_sel = '0;
    i_rst = 1'b1;
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    axi_rd(A_CTRL);
    chk("ctrl", rd, CTRL_RST);
    axi_rd(A_LIST0);
    chk("list0", rd, 32'h0);
    axi_rd(A_EOT);
    chk("eot", rd, 32'h0);
    axi_rd(8'h40);
    chk("rresp", rr, 2'h2);
    axi_wr(8'h40, 32'h1);
    chk("bresp", rr, 2'h2);
    axi_wr(A_EOT, 32'd11000);
    axi_wr(A_CTRL, 32'h1);
    for (int i = 0; i < 10; i++) begin
      res_sel <= rows[i].res;
      put_td(16'h80, rows[i], 16'h0110);
      put_td(16'h88, rows[i], 16'h0000);
      i_far_model.mem[16'ha2] = 16'h0;
      axi_wr(A_LIST0, 32'h100);
      run_list();
      chk("mailbox", w(16'ha2), MSG_DONE);
      chk("status", w(16'h83) >> 8, rows[i].st);
      chk("retry", w(16'h84) & 16'hff, rows[i].rty);
      chk("residue", w(16'h84) >> 8, rows[i].rsd);
      chk("control", w(16'h83) & 16'hff, {3'h0, rows[i].kind == K_ISO, 4'h1});
      chk("link", w(16'h85), 16'h0110);
      chk("length", w(16'h81), 16'h0008);
      chk("status2", w(16'h8b) >> 8, rows[i].halt ? 8'h00 : rows[i].st);
      chk("retry2", w(16'h8c) & 16'hff,
        rows[i].halt ? {4'h0, rows[i].kind, 2'h3} : rows[i].rty);
      axi_rd(A_LIST0);
      chk("list0", rd, 32'h0);
      $display("list test %0d done", i);
    end
    // nak until the budget runs out leaves the descriptor untouched
    axi_wr(A_EOT, 32'd1000);
    res_sel <= 16'h1000;
    put_td(16'h80, rows[0], 16'h0000);
    i_far_model.mem[16'ha2] = 16'h0;
    axi_wr(A_LIST0, 32'h100);
    run_list();
    chk("nak_status", w(16'h83) >> 8, 32'h0);
    chk("nak_retry", w(16'h84) & 16'hff, 32'h1b);
    chk("nak_mailbox", w(16'ha2), 32'h0);
    axi_rd(A_LIST0);
    chk("nak_list0", rd, 32'h100);
    res_sel <= 16'h8000;
    run_list();
    chk("nak_done", w(16'h83) >> 8, 32'h1);
    $display("nak test done");
    for (int p = 0; p < 2; p++) begin
      i_port_attached <= {2'h0, p == 0, 1'b0};
      i_port_low_speed <= {2'h0, p == 0, 1'b0};
      axi_wr(A_PRST, {16'd2, 16'd1});
      repeat (2) @(posedge i_mclk);
      chk("port_reset", o_port_reset, 4'h2);
      for (int k = 0; k < 50; k++) begin
        axi_rd(A_PRST);
        if (!rd[2]) break;
      end
      axi_rd(A_PRES);
      chk("port_result", rd, p == 0 ? 32'h1 : 32'h2);
      chk("port_idle", o_port_reset, 4'h0);
      $display("port test %0d done", p);
    end
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    axi_rd(A_CTRL);
    chk("ctrl", rd, CTRL_RST);
    $display("reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
